// ===== design/acl_rule_pkg.sv
// constants, field layouts and carrier types of the acl matching rule evaluator
// Functional notes
// - rule mode 00 disables the rule; never a true match
// - rule mode 01 layer 2 or counter, 10 IPv4, 11 layer 4 filtering
// - layer 2: 01 MAC, 10 EtherType, 00 count mode tests both
// - layer 2 select 11 needs 48-bit MAC and 16-bit EtherType
// - direction bit picks destination at 0, source at 1
// - polarity 1 makes equal true; polarity 0 makes not-equal true
// - count value: prio mode, prio, remark enable, remark prio, map mode
// - time unit bit selects microsecond at 0, millisecond at 1
// - algorithm 0 loads counter, decrements per unit, interrupts on expiry
// - algorithm 1 counts matching frames, interrupts at terminal count, then resets
// - layer 3: 01 one masked address, 10 both unmasked; others reserved
// - address field: direction-chosen at 01, source at 10
// - layer 3 select 01: mask bit 1 drops that address bit
// - layer 3 select 10: mask field is the destination address
// - layer 4 select: 00 protocol, 01 TCP ports, 10 UDP ports, 11 sequence
// - limit field holds max and min 16-bit ports, or one 32-bit sequence
// - port mode: 00 off, 01 equals a limit, 10 inside range, 11 outside
// - protocol test compares 8-bit IPv4 protocol with the stored value
// - flag match enable 1 adds a TCP flag byte test; 0 skips it
// - flag mask bit 0 compares that flag bit, 1 ignores it
// - AND results selected by each bitmap; lowest true action pointer wins
// - count interrupts per port, maskable; filtering never interrupts
package acl_rule_pkg;

  localparam int NUM_RULES = 16;
  localparam int NUM_PORTS = 7;
  localparam int CNT_W = 11;

  // clock and time base
  localparam int CLK_PERIOD_NS = 8;
  localparam int US_NS = 1000;
  localparam int CYC_PER_US = US_NS / CLK_PERIOD_NS;
  localparam int US_PER_MS = 1000;

  // apb byte offsets
  localparam logic [7:0] OFF_MATCH_CTRL = 8'h00;
  localparam logic [7:0] OFF_MAC_LO = 8'h04;
  localparam logic [7:0] OFF_MAC_HI = 8'h08;
  localparam logic [7:0] OFF_IP_ADDR = 8'h0c;
  localparam logic [7:0] OFF_IPV4_BIT_MASK = 8'h10;
  localparam logic [7:0] OFF_L4_LIMIT = 8'h14;
  localparam logic [7:0] OFF_FLAGS = 8'h18;
  localparam logic [7:0] OFF_ACTION = 8'h1c;
  localparam logic [7:0] OFF_CNT_STATUS = 8'h20;
  localparam logic [7:0] OFF_INT_STATUS = 8'h24;
  localparam logic [7:0] OFF_INT_MASK = 8'h28;
  localparam logic [7:0] OFF_PROC_BASE = 8'h40;
  localparam logic [7:0] OFF_PROC_LAST = 8'h7c;

  // field positions in the words above
  localparam int MC_MODE_LSB = 0;
  localparam int MC_SEL_LSB = 2;
  localparam int MC_DIR_BIT = 4;
  localparam int MC_POL_BIT = 5;
  localparam int MC_PCM_LSB = 6;
  localparam int MC_FME_BIT = 8;
  localparam int MC_PROTO_LSB = 16;
  localparam int MH_TYPE_LSB = 16;
  localparam int FL_MASK_LSB = 8;
  localparam int AC_TU_BIT = 11;
  localparam int AC_CA_BIT = 12;
  localparam int CS_ARMED_BIT = 16;
  localparam int PE_PTR_LSB = 16;

  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_L2 = 2'b01,
    MODE_L3 = 2'b10,
    MODE_L4 = 2'b11
  } rule_mode_t;

  typedef enum logic [1:0] {
    PCM_OFF = 2'b00,
    PCM_EITHER = 2'b01,
    PCM_INSIDE = 2'b10,
    PCM_OUTSIDE = 2'b11
  } port_compare_mode_t;

  localparam logic [1:0] SEL_00 = 2'b00;
  localparam logic [1:0] SEL_01 = 2'b01;
  localparam logic [1:0] SEL_10 = 2'b10;
  localparam logic [1:0] SEL_11 = 2'b11;

  typedef struct packed {
    logic valid;
    logic [2:0] ingress_port;
    logic [47:0] dst_mac;
    logic [47:0] src_mac;
    logic [15:0] ethertype;
    logic [31:0] src_ip;
    logic [31:0] dst_ip;
    logic [7:0] ip_proto;
    logic is_tcp;
    logic is_udp;
    logic [15:0] src_port;
    logic [15:0] dst_port;
    logic [31:0] tcp_seq;
    logic [7:0] tcp_flags;
  } frame_hdr_t;

  typedef struct packed {
    logic valid;
    logic rule_match;
    logic action_hit;
    logic [3:0] action_pointer;
  } match_result_t;

endpackage : acl_rule_pkg

// ===== design/acl_match_rule_evaluator.sv
// one acl matching rule with its action entry, count mode and processing stage
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module acl_match_rule_evaluator
  import acl_rule_pkg::*;
#(
  parameter logic [3:0] RULE_INDEX = 4'h0
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire frame_hdr_t frame_hdr,
  input wire logic [NUM_RULES-1:0] other_match,
  output match_result_t result,
  output logic [NUM_PORTS-1:0] count_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // register storage

  rule_mode_t rule_mode;
  logic [1:0] compare_select;
  logic addr_dir;
  logic match_polarity;
  port_compare_mode_t port_compare_mode;
  logic flag_match_enable;
  logic [7:0] ip_protocol_value;
  logic [47:0] mac_value;
  logic [15:0] type_value;
  logic [31:0] ip_addr_value;
  logic [31:0] ipv4_bit_mask;
  logic [31:0] l4_limit;
  logic [7:0] flag_value;
  logic [7:0] flag_bit_mask;
  logic [1:0] prio_mode;
  logic [2:0] prio;
  logic remark_enable;
  logic [2:0] remark_prio;
  logic [1:0] map_mode;
  logic time_unit_sel;
  logic counter_algorithm;
  logic [NUM_PORTS-1:0] int_status;
  logic [NUM_PORTS-1:0] int_mask;
  logic [15:0] rule_select_bitmap [NUM_RULES];
  logic [3:0] action_pointer [NUM_RULES];

  logic [CNT_W-1:0] count_reg;
  logic armed;
  logic [2:0] last_port;
  logic [NUM_PORTS-1:0] fire_vec;

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait states, data and error captured in setup

  logic setup_phase;
  logic wr_access;
  logic proc_hit;
  logic [3:0] proc_idx;
  logic addr_ok;
  logic [31:0] rd_mux;

  assign pready = 1'b1;
  assign setup_phase = psel && !penable;
  assign wr_access = ce && psel && penable && pwrite && addr_ok;
  assign proc_hit = (paddr >= OFF_PROC_BASE) && (paddr <= OFF_PROC_LAST) && (paddr[1:0] == 2'b00);
  assign proc_idx = paddr[5:2];

  always_comb
  begin
    addr_ok = 1'b1;
    rd_mux = '0;
    if (proc_hit)
    begin
      rd_mux[15:0] = rule_select_bitmap[proc_idx];
      rd_mux[PE_PTR_LSB +: 4] = action_pointer[proc_idx];
    end
    else
    begin
      case (paddr)
        OFF_MATCH_CTRL:
        begin
          rd_mux[MC_MODE_LSB +: 2] = rule_mode;
          rd_mux[MC_SEL_LSB +: 2] = compare_select;
          rd_mux[MC_DIR_BIT] = addr_dir;
          rd_mux[MC_POL_BIT] = match_polarity;
          rd_mux[MC_PCM_LSB +: 2] = port_compare_mode;
          rd_mux[MC_FME_BIT] = flag_match_enable;
          rd_mux[MC_PROTO_LSB +: 8] = ip_protocol_value;
        end
        OFF_MAC_LO: rd_mux = mac_value[31:0];
        OFF_MAC_HI: rd_mux = {type_value, mac_value[47:32]};
        OFF_IP_ADDR: rd_mux = ip_addr_value;
        OFF_IPV4_BIT_MASK: rd_mux = ipv4_bit_mask;
        OFF_L4_LIMIT: rd_mux = l4_limit;
        OFF_FLAGS: rd_mux[15:0] = {flag_bit_mask, flag_value};
        OFF_ACTION:
        begin
          rd_mux[CNT_W-1:0] = {prio_mode, prio, remark_enable, remark_prio, map_mode};
          rd_mux[AC_TU_BIT] = time_unit_sel;
          rd_mux[AC_CA_BIT] = counter_algorithm;
        end
        OFF_CNT_STATUS:
        begin
          rd_mux[CNT_W-1:0] = count_reg;
          rd_mux[CS_ARMED_BIT] = armed;
        end
        OFF_INT_STATUS: rd_mux[NUM_PORTS-1:0] = int_status;
        OFF_INT_MASK: rd_mux[NUM_PORTS-1:0] = int_mask;
        default: addr_ok = 1'b0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= '0;
      pslverr <= 1'b0;
    end
    else if (ce && setup_phase)
    begin
      prdata <= pwrite ? '0 : rd_mux;
      pslverr <= !addr_ok;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rule_mode <= MODE_OFF;
      compare_select <= SEL_00;
      addr_dir <= 1'b0;
      match_polarity <= 1'b0;
      port_compare_mode <= PCM_OFF;
      flag_match_enable <= 1'b0;
      ip_protocol_value <= 8'h00;
      mac_value <= '0;
      type_value <= '0;
      ip_addr_value <= '0;
      ipv4_bit_mask <= '0;
      l4_limit <= '0;
      flag_value <= 8'h00;
      flag_bit_mask <= 8'h00;
      prio_mode <= 2'h0;
      prio <= 3'h0;
      remark_enable <= 1'b0;
      remark_prio <= 3'h0;
      map_mode <= 2'h0;
      time_unit_sel <= 1'b0;
      counter_algorithm <= 1'b0;
      int_mask <= '0;
      for (int i = 0; i < NUM_RULES; i++)
      begin
        rule_select_bitmap[i] <= 16'h0000;
        action_pointer[i] <= 4'h0;
      end
    end
    else if (wr_access)
    begin
      if (proc_hit)
      begin
        rule_select_bitmap[proc_idx] <= pwdata[15:0];
        action_pointer[proc_idx] <= pwdata[PE_PTR_LSB +: 4];
      end
      else
      begin
        case (paddr)
          OFF_MATCH_CTRL:
          begin
            rule_mode <= rule_mode_t'(pwdata[MC_MODE_LSB +: 2]);
            compare_select <= pwdata[MC_SEL_LSB +: 2];
            addr_dir <= pwdata[MC_DIR_BIT];
            match_polarity <= pwdata[MC_POL_BIT];
            port_compare_mode <= port_compare_mode_t'(pwdata[MC_PCM_LSB +: 2]);
            flag_match_enable <= pwdata[MC_FME_BIT];
            ip_protocol_value <= pwdata[MC_PROTO_LSB +: 8];
          end
          OFF_MAC_LO: mac_value[31:0] <= pwdata;
          OFF_MAC_HI:
          begin
            mac_value[47:32] <= pwdata[15:0];
            type_value <= pwdata[MH_TYPE_LSB +: 16];
          end
          OFF_IP_ADDR: ip_addr_value <= pwdata;
          OFF_IPV4_BIT_MASK: ipv4_bit_mask <= pwdata;
          OFF_L4_LIMIT: l4_limit <= pwdata;
          OFF_FLAGS:
          begin
            flag_value <= pwdata[7:0];
            flag_bit_mask <= pwdata[FL_MASK_LSB +: 8];
          end
          OFF_ACTION:
          begin
            {prio_mode, prio, remark_enable, remark_prio, map_mode} <= pwdata[CNT_W-1:0];
            time_unit_sel <= pwdata[AC_TU_BIT];
            counter_algorithm <= pwdata[AC_CA_BIT];
          end
          OFF_INT_MASK: int_mask <= pwdata[NUM_PORTS-1:0];
          default:
          begin
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // field comparisons

  logic [47:0] sel_mac;
  logic mac_hit;
  logic type_hit;
  logic l2_raw;
  logic l2_true;
  logic [31:0] sel_ip;
  logic l3_raw;
  logic l3_true;
  logic [15:0] sel_port;
  logic [15:0] port_max;
  logic [15:0] port_min;
  logic port_hit;
  logic flag_hit;
  logic l4_raw;
  logic l4_true;
  logic own_match;
  logic count_mode;

  assign sel_mac = addr_dir ? frame_hdr.src_mac : frame_hdr.dst_mac;
  assign sel_ip = addr_dir ? frame_hdr.src_ip : frame_hdr.dst_ip;
  assign sel_port = addr_dir ? frame_hdr.src_port : frame_hdr.dst_port;
  assign mac_hit = (sel_mac == mac_value);
  assign type_hit = (frame_hdr.ethertype == type_value);
  assign port_max = l4_limit[31:16];
  assign port_min = l4_limit[15:0];
  assign flag_hit = !flag_match_enable || (((frame_hdr.tcp_flags ^ flag_value) & ~flag_bit_mask) == 8'h00);
  assign count_mode = (rule_mode == MODE_L2) && (compare_select == SEL_00);

  always_comb
  begin
    case (compare_select)
      SEL_01: l2_raw = mac_hit;
      SEL_10: l2_raw = type_hit;
      default: l2_raw = mac_hit && type_hit;
    endcase
    // polarity applied to the raw comparison
    l2_true = match_polarity ? l2_raw : !l2_raw;
  end

  always_comb
  begin
    case (compare_select)
      SEL_01: l3_raw = ((sel_ip ^ ip_addr_value) & ~ipv4_bit_mask) == '0;
      SEL_10: l3_raw = (frame_hdr.src_ip == ip_addr_value) && (frame_hdr.dst_ip == ipv4_bit_mask);
      default: l3_raw = 1'b0;
    endcase
    // reserved selects stay false whatever the polarity
    l3_true = (compare_select inside {SEL_01, SEL_10}) && (match_polarity ? l3_raw : !l3_raw);
  end

  always_comb
  begin
    case (port_compare_mode)
      PCM_EITHER: port_hit = (sel_port == port_max) || (sel_port == port_min);
      PCM_INSIDE: port_hit = (sel_port >= port_min) && (sel_port <= port_max);
      PCM_OUTSIDE: port_hit = (sel_port < port_min) || (sel_port > port_max);
      default: port_hit = 1'b1;
    endcase
    case (compare_select)
      SEL_00: l4_raw = (frame_hdr.ip_proto == ip_protocol_value);
      SEL_01: l4_raw = frame_hdr.is_tcp && port_hit;
      SEL_10: l4_raw = frame_hdr.is_udp && port_hit;
      default: l4_raw = frame_hdr.is_tcp && (frame_hdr.tcp_seq == l4_limit);
    endcase
    // protocol compare sits in select 00 above
    l4_true = (match_polarity ? l4_raw : !l4_raw) && flag_hit;
  end

  always_comb
  begin
    case (rule_mode)
      MODE_L2: own_match = !count_mode && l2_true;
      MODE_L3: own_match = l3_true;
      MODE_L4: own_match = l4_true;
      default: own_match = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // processing entries: and over each bitmap, lowest pointer wins

  logic [NUM_RULES-1:0] match_vec;
  logic best_hit;
  logic [3:0] best_ptr;

  always_comb
  begin
    match_vec = other_match;
    match_vec[RULE_INDEX] = own_match;
    best_hit = 1'b0;
    best_ptr = 4'h0;
    // and per entry, lowest pointer among true entries
    for (int i = 0; i < NUM_RULES; i++)
    begin
      if ((rule_select_bitmap[i] != 16'h0000) && ((rule_select_bitmap[i] & ~match_vec) == 16'h0000))
      begin
        if (!best_hit || (action_pointer[i] < best_ptr))
        begin
          best_ptr = action_pointer[i];
        end
        best_hit = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      result <= '0;
    end
    else if (ce)
    begin
      result.valid <= frame_hdr.valid;
      result.rule_match <= frame_hdr.valid && own_match;
      result.action_hit <= frame_hdr.valid && best_hit;
      result.action_pointer <= best_ptr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // time base for count mode

  logic [6:0] us_div;
  logic [9:0] ms_div;
  logic us_tick;
  logic ms_tick;
  logic unit_tick;

  assign us_tick = (us_div == 7'(CYC_PER_US - 1));
  assign ms_tick = us_tick && (ms_div == 10'(US_PER_MS - 1));
  assign unit_tick = time_unit_sel ? ms_tick : us_tick;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      us_div <= 7'h00;
      ms_div <= 10'h000;
    end
    else if (ce)
    begin
      us_div <= us_tick ? 7'h00 : us_div + 7'h01;
      if (us_tick)
      begin
        ms_div <= ms_tick ? 10'h000 : ms_div + 10'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // count mode counter

  logic qualify;
  logic [CNT_W-1:0] count_value;
  logic fire;
  logic [2:0] fire_port;

  assign count_value = {prio_mode, prio, remark_enable, remark_prio, map_mode};
  // qualifying frames: count mode tests mac and type together
  assign qualify = ce && frame_hdr.valid && count_mode && l2_true;

  always_comb
  begin
    fire = 1'b0;
    fire_port = last_port;
    if (count_mode)
    begin
      if (counter_algorithm)
      begin
        // terminal count reached on this frame
        fire = qualify && ((count_reg + 11'h001) >= count_value);
        fire_port = frame_hdr.ingress_port;
      end
      else
      begin
        // expiry when the last unit elapses
        fire = ce && !qualify && armed && unit_tick && (count_reg <= 11'h001);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_reg <= '0;
      armed <= 1'b0;
      last_port <= 3'h0;
    end
    else if (ce)
    begin
      if (!count_mode)
      begin
        count_reg <= '0;
        armed <= 1'b0;
      end
      else if (counter_algorithm)
      begin
        armed <= 1'b0;
        if (qualify)
        begin
          count_reg <= fire ? '0 : count_reg + 11'h001;
        end
      end
      else if (qualify)
      begin
        // every qualifying frame restarts the interval
        count_reg <= count_value;
        armed <= 1'b1;
        last_port <= frame_hdr.ingress_port;
      end
      else if (armed && unit_tick)
      begin
        // down-count, stops after expiry until the next frame
        count_reg <= (count_reg == '0) ? '0 : count_reg - 11'h001;
        armed <= !fire;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per port count status; a new event beats a clear in the same cycle

  always_comb
  begin
    fire_vec = '0;
    if (fire && (fire_port < 3'(NUM_PORTS)))
    begin
      fire_vec[fire_port] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      int_status <= '0;
      count_irq <= '0;
    end
    else if (ce)
    begin
      // sticky per port status, write one to clear
      if (wr_access && (paddr == OFF_INT_STATUS))
      begin
        int_status <= (int_status & ~pwdata[NUM_PORTS-1:0]) | fire_vec;
      end
      else
      begin
        int_status <= int_status | fire_vec;
      end
      count_irq <= int_status & int_mask;
    end
  end

endmodule : acl_match_rule_evaluator

// ===== verification/acl_rule_assertions.sv
// port checks for the acl rule evaluator
`timescale 1ns/1ps
module acl_rule_assertions
  import acl_rule_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  input wire frame_hdr_t frame_hdr,
  input wire match_result_t result,
  input wire logic [NUM_PORTS-1:0] count_irq
);
  logic [31:0] sh [0:15];
  logic l2m;
  logic cnt_seen;
  ////////////////////////////////////////////////////////////
  // shadow of the low words
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sh <= '{default: '0};
    else if (psel && penable && pwrite && ce && paddr < 8'h40)
      sh[paddr[5:2]] <= pwdata;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_seen <= 1'b0;
    else if (sh[0][3:0] == 4'h1)
      cnt_seen <= 1'b1;
  end
  assign l2m = ((sh[0][4] ? frame_hdr.src_mac : frame_hdr.dst_mac) == {sh[2][15:0], sh[1]}) == sh[0][5];
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_frame;
    frame_hdr.valid && ce;
  endsequence
  sequence s_setup;
    psel && !penable && ce;
  endsequence
  a_off_no_match: assert property (s_frame ##0 (sh[0][1:0] == 2'b00) |=> !result.rule_match)
    else $error("disabled rule matched");
  a_result_follows: assert property (s_frame |=> result.valid)
    else $error("no result after frame");
  a_l2_compare: assert property (s_frame ##0 (sh[0][3:0] == 4'h5) |=> result.rule_match == $past(l2m))
    else $error("mac compare wrong");
  a_count_no_match: assert property (s_frame ##0 (sh[0][3:0] == 4'h1) |=> !result.rule_match)
    else $error("count rule matched");
  a_l3_reserved: assert property (s_frame ##0 (sh[0][1:0] == 2'b10 && sh[0][3:2] inside {2'b00, 2'b11})
    |=> !result.rule_match)
    else $error("reserved select matched");
  a_irq_masked: assert property ((count_irq & ~$past(sh[10][6:0])) == '0)
    else $error("irq on masked port");
  a_filter_silent: assert property (!cnt_seen |-> count_irq == '0)
    else $error("irq without count mode");
  a_pointer_idle: assert property (result.valid && !result.action_hit |-> result.action_pointer == 4'h0)
    else $error("pointer without hit");
  a_err_unmapped: assert property (s_setup ##0 ((paddr > 8'h28 && paddr < 8'h40) || paddr > 8'h7c)
    |=> pslverr [*2])
    else $error("unmapped access not flagged");
endmodule : acl_rule_assertions

// ===== verification/frame_source.sv
// parsed header source in place of the switch frame parser
`timescale 1ns/1ps
module frame_source
  import acl_rule_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire frame_hdr_t hdr,
  input wire logic [NUM_RULES-1:0] others,
  output frame_hdr_t frame_hdr,
  output logic [NUM_RULES-1:0] other_match
);
  // between frames the fields toggle so nothing leans on stale values
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      frame_hdr <= '0;
      other_match <= '0;
    end
    else if (go)
    begin
      frame_hdr <= hdr;
      other_match <= others;
    end
    else
    begin
      frame_hdr <= {1'b0, ~frame_hdr[$bits(frame_hdr_t)-2:0]};
      other_match <= ~other_match;
    end
  end
endmodule : frame_source

// ===== verification/acl_match_rule_evaluator_test.sv
// self-checking bench for the acl rule evaluator
`timescale 1ns/1ps
module acl_match_rule_evaluator_test
  import acl_rule_pkg::*;
;
  localparam logic [3:0] RI = 4'h2;
  logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, er, m;
  frame_hdr_t fh, fr, hdr = '0;
  logic [15:0] om, o, v, oth = '0;
  match_result_t result, xr;
  logic [NUM_PORTS-1:0] count_irq;
  logic [31:0] cfg [0:6];
  logic [31:0] pe [0:15];
  logic [287:0] rb;
  int error_cnt = 0, samples_checked = 0, i, j, k;
  ////////////////////////////////////////////////////////////
  acl_match_rule_evaluator #(.RULE_INDEX(RI)) DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .frame_hdr(fh), .other_match(om), .result(result), .count_irq(count_irq));
  frame_source u_src (.pclk(pclk), .presetn(presetn), .go(go), .hdr(hdr), .others(oth), .frame_hdr(fh),
    .other_match(om));
  always #(CLK_PERIOD_NS / 2) pclk = ~pclk;
  ////////////////////////////////////////////////////////////
  task automatic results;
    $display("mismatches %0d of %0d checks", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results
  task automatic tmo;
    error_cnt++;
    results();
  endtask : tmo
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (n == 20)
      tmo();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic frm(input frame_hdr_t f, input logic [15:0] ov);
    int n;
    @(posedge pclk);
    go <= 1'b1;
    hdr <= f;
    oth <= ov;
    @(posedge pclk);
    go <= 1'b0;
    for (n = 0; n < 8; n++)
    begin
      @(negedge pclk);
      if (result.valid === 1'b1)
        break;
    end
    if (n == 8)
      tmo();
  endtask : frm
  ////////////////////////////////////////////////////////////
  function automatic logic em(frame_hdr_t f);
    logic [31:0] c;
    logic [47:0] mac;
    logic [15:0] p;
    logic e;
    c = cfg[0];
    mac = {cfg[2][15:0], cfg[1]};
    p = f.dst_port;
    case ({c[1:0], c[3:2]})
      4'h5: e = (c[4] ? f.src_mac : f.dst_mac) == mac;
      4'h6: e = f.ethertype == cfg[2][31:16];
      4'h7: e = (c[4] ? f.src_mac : f.dst_mac) == mac && f.ethertype == cfg[2][31:16];
      4'h9: e = (((c[4] ? f.src_ip : f.dst_ip) ^ cfg[3]) & ~cfg[4]) == 32'h0;
      4'ha: e = f.src_ip == cfg[3] && f.dst_ip == cfg[4];
      4'hc: e = f.ip_proto == c[23:16];
      4'hd, 4'he: e = c[7:6] == 2'h0 || (c[7:6] == 2'h1 ? (p == cfg[5][31:16] || p == cfg[5][15:0]) :
        ((p >= cfg[5][15:0] && p <= cfg[5][31:16]) == (c[7:6] == 2'h2)));
      4'hf: e = f.tcp_seq == cfg[5];
      default: return 1'b0;
    endcase
    if (c[1:0] == 2'h3 && c[8] && ((f.tcp_flags ^ cfg[6][7:0]) & ~cfg[6][15:8]) != 8'h0)
      return 1'b0;
    return e == c[5];
  endfunction : em
  function automatic logic [4:0] ea(logic [15:0] mv);
    logic [4:0] r;
    r = 5'h0;
    for (int n = 0; n < 16; n++)
      if (pe[n][15:0] != 16'h0 && (mv & pe[n][15:0]) == pe[n][15:0] && (!r[4] || pe[n][19:16] < r[3:0]))
        r = {1'b1, pe[n][19:16]};
    return r;
  endfunction : ea
  ////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(58729));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 12; i++)
    begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b1, 8'h30, 32'hffff);
    apb(1'b0, 8'h30, 32'h0);
    chk(32'(er), 32'h1);
    for (i = 0; i < 16; i++)
    begin
      pe[i] = {12'h0, 4'($urandom), 16'($urandom & $urandom & $urandom)};
      if (i == 0)
        pe[i] = 32'h000f_0000 | (32'h1 << RI);
      apb(1'b1, 8'(OFF_PROC_BASE + 4 * i), pe[i]);
    end
    // every mode, select, direction and polarity code
    for (k = 0; k < 64; k++)
    begin
      cfg[0] = {8'h0, 8'($urandom), 7'h0, 1'($urandom), 2'($urandom), 6'(k)};
      for (i = 1; i < 7; i++)
        cfg[i] = $urandom;
      cfg[4] &= $urandom;
      cfg[6] &= 32'hffff;
      for (i = 0; i < 7; i++)
      begin
        apb(1'b1, 8'(4 * i), cfg[i]);
        apb(1'b0, 8'(4 * i), 32'h0);
        chk(rd, cfg[i]);
      end
      for (j = 0; j < 4; j++)
      begin
        for (i = 0; i < 9; i++)
          rb[32 * i +: 32] = $urandom;
        fr = rb[261:0];
        fr.valid = 1'b1;
        fr.ingress_port = 3'($urandom % 7);
        fr.is_tcp = cfg[0][3:2] != 2'h2;
        fr.is_udp = !fr.is_tcp;
        if (j[0])
        begin
          fr.dst_mac = {cfg[2][15:0], cfg[1]};
          fr.src_mac = fr.dst_mac;
          fr.ethertype = cfg[2][31:16];
          fr.src_ip = cfg[3];
          fr.dst_ip = cfg[0][3:2] == 2'h2 ? cfg[4] : cfg[3];
          fr.ip_proto = cfg[0][23:16];
          fr.src_port = j[1] ? cfg[5][31:16] : cfg[5][15:0];
          fr.tcp_seq = cfg[5];
          fr.tcp_flags = cfg[6][7:0] ^ (cfg[6][15:8] & 8'($urandom));
        end
        // spoil the side the direction bit does not pick
        if (j == 1 && cfg[0][4])
          {fr.dst_mac, fr.dst_ip} = ~{fr.dst_mac, fr.dst_ip};
        else if (j == 1)
          {fr.src_mac, fr.src_ip} = ~{fr.src_mac, fr.src_ip};
        fr.dst_port = fr.src_port;
        o = 16'($urandom);
        m = em(fr);
        v = o;
        v[RI] = m;
        xr = {1'b1, m, ea(v)};
        frm(fr, o);
        chk(32'(result), 32'(xr));
      end
    end
    // event counter, count 3, port 5 unmasked
    apb(1'b1, OFF_MATCH_CTRL, 32'h21);
    apb(1'b1, OFF_INT_STATUS, 32'h7f);
    apb(1'b1, OFF_INT_MASK, 32'h20);
    apb(1'b1, OFF_ACTION, 32'h1003);
    fr.dst_mac = {cfg[2][15:0], cfg[1]};
    fr.ethertype = cfg[2][31:16];
    fr.ingress_port = 3'h5;
    frm(fr, 16'h0);
    frm(fr, 16'h0);
    apb(1'b0, OFF_CNT_STATUS, 32'h0);
    chk(32'(rd[10:0]), 32'h2);
    apb(1'b0, OFF_INT_STATUS, 32'h0);
    chk(rd, 32'h0);
    frm(fr, 16'h0);
    apb(1'b0, OFF_INT_STATUS, 32'h0);
    chk(rd, 32'h20);
    chk(32'(count_irq), 32'h20);
    apb(1'b0, OFF_CNT_STATUS, 32'h0);
    chk(32'(rd[10:0]), 32'h0);
    apb(1'b1, OFF_INT_STATUS, 32'h20);
    apb(1'b0, OFF_INT_STATUS, 32'h0);
    chk(rd, 32'h0);
    // watchdog in microseconds; port 1 stays masked
    apb(1'b1, OFF_ACTION, 32'h0003);
    fr.ingress_port = 3'h1;
    frm(fr, 16'h0);
    repeat (240) @(posedge pclk);
    frm(fr, 16'h0);
    repeat (236) @(posedge pclk);
    apb(1'b0, OFF_INT_STATUS, 32'h0);
    chk(rd, 32'h0);
    repeat (140) @(posedge pclk);
    apb(1'b0, OFF_INT_STATUS, 32'h0);
    chk(rd, 32'h2);
    chk(32'(count_irq), 32'h0);
    apb(1'b1, OFF_INT_STATUS, 32'h7f);
    apb(1'b1, OFF_ACTION, 32'h0803);
    frm(fr, 16'h0);
    repeat (400) @(posedge pclk);
    apb(1'b0, OFF_INT_STATUS, 32'h0);
    chk(rd, 32'h0);
    results();
  end
endmodule : acl_match_rule_evaluator_test

bind acl_match_rule_evaluator acl_rule_assertions u_chk (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .frame_hdr(frame_hdr),
  .result(result), .count_irq(count_irq));
